// file: core/frac_sdm_fastlock_resync.sv
// top of the synthesizer control core: control words, fast lock, resync, noise shaper
//
// Behaviour
// (R1) mode 01 starts fast lock, loads timer
// (R2) wide bandwidth lasts timer-derived comparison cycles
// (R3) charge pump current sixteenfold during fast lock
// (R4) switch pin grounded during fast lock
// (R5) host initialises once, then writes word 3
// (R6) third-order shaper, divisor base 2..4095
// (R7) host keeps base >= 50 with dither
// (R8) shaper steps once per comparison cycle
// (R9) dither off repeat length follows base
// (R10) dither on repeat length 2^21
// (R11) phase word seeds the shaper
// (R12) mode 10 enables phase resync
// (R13) sync every count x base comparison cycles
// (R14) resync count from word 3 field
// (R15) divisor base from word 1 field
// (R16) resync on second sync after latch
// (R17) host picks interval above lock time
// (R18) phase word sets output phase step
// (R19) resync gives repeatable phase offset
// (R20) host keeps phase word constant
// (R21) latched word goes to addressed register
// (R22) host writes registers 5 down to 0
// (R23) fast lock lasts timer x base cycles
// (R24) mode 00: no fast lock, no sync
`timescale 1ns/1ps
`include "frac_sdm_map.svh"
module frac_sdm_fastlock_resync (
  // clock and reset (comparison clock)
  input wire logic clk,
  input wire logic rst_n,
  // comparison cycle strobe
  input wire logic compare_tick,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // loop control outputs
  output logic fastlock_switch_pin_o,
  output logic fastlock_switch_pin_oe,
  output logic [7:0] cp_current_q,
  output logic sync_pulse_q,
  output logic phase_resync_q,
  output logic signed [3:0] divider_offset_q
);

  // ****************************************************************
  // state
  // ****************************************************************
  logic [31:0] word_q [6];
  logic [11:0] frac_q;
  logic aw_hold_q, w_hold_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic latch_strobe;
  logic [2:0] latch_idx;
  logic [31:0] latch_word;
  logic [31:0] rd_mux;
  logic rd_ok;
  frac_sdm_pkg::clkdiv_mode_e mode;
  logic [11:0] modulus, clk_div;
  logic fast_active_q;
  logic [23:0] fast_cnt_q;
  logic [11:0] base_cnt_q, per_cnt_q;
  logic [1:0] sync_seen_q;
  logic resync_arm_q;
  logic sync_now;
  logic reseed;
  logic signed [3:0] shaper_dn;
  frac_sdm_pkg::shaper_cfg_s cfg;

  // ****************************************************************
  // write channel: address and data taken in either order
  // ****************************************************************
  // holding each half keeps the response honest when the two arrive apart
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        wdata_q <= s_axi_wdata;
      end
      if (aw_hold_q && w_hold_q && !s_axi_bvalid) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_q <= `OFF_FRAC && awaddr_q[1:0] == 2'b00) ? 2'b00 : 2'b10;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
  assign s_axi_wready = !w_hold_q && !s_axi_bvalid;

  // a serial-style word write: low three bits address the control word
  always_comb begin
    latch_strobe = aw_hold_q && w_hold_q && !s_axi_bvalid;
    latch_word = wdata_q;
    latch_idx = wdata_q[`ADDR_MSB:`ADDR_LSB];
  end

  // control word store; byte strobes ignored, words are atomic
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 6; i++) word_q[i] <= `RST_WORD;
      frac_q <= '0;
    end else if (latch_strobe) begin
      if (awaddr_q <= `OFF_WORD5 && latch_idx < 3'd6) begin
        word_q[latch_idx] <= latch_word; // (R21)
      end else if (awaddr_q == `OFF_FRAC) begin
        frac_q <= latch_word[11:0];
      end
    end
  end

  // ****************************************************************
  // read channel
  // ****************************************************************
  always_comb begin
    rd_mux = '0;
    rd_ok = 1'b1;
    case (s_axi_araddr)
      `OFF_WORD0: rd_mux = word_q[0];
      `OFF_WORD1: rd_mux = word_q[1];
      `OFF_WORD2: rd_mux = word_q[2];
      `OFF_WORD3: rd_mux = word_q[3];
      `OFF_WORD4: rd_mux = word_q[4];
      `OFF_WORD5: rd_mux = word_q[5];
      `OFF_FRAC: rd_mux = {20'h0_0000, frac_q};
      `OFF_STATUS: rd_mux = {26'h000_0000, sync_seen_q, resync_arm_q, phase_resync_q,
                             sync_pulse_q, fast_active_q};
      `OFF_PHASE_OUT: rd_mux = {28'h000_0000, divider_offset_q};
      default: rd_ok = 1'b0;
    endcase
  end

  // one-deep read; address taken only when no answer is pending
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_ok ? 2'b00 : 2'b10;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  assign s_axi_arready = !s_axi_rvalid;

  // ****************************************************************
  // field decode
  // ****************************************************************
  always_comb begin
    mode = frac_sdm_pkg::clkdiv_mode_e'(word_q[3][`CLKMODE_MSB:`CLKMODE_LSB]);
    clk_div = word_q[3][`FIELD_MSB:`FIELD_LSB]; // (R2) (R14)
    modulus = word_q[1][`FIELD_MSB:`FIELD_LSB]; // (R15)
    if (modulus < `RST_MODULUS) modulus = `RST_MODULUS; // (R6)
  end

  // ****************************************************************
  // fast lock timer
  // ****************************************************************
  // writing word 3 with mode 01 restarts the wide-bandwidth interval
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fast_active_q <= 1'b0;
      fast_cnt_q <= '0;
    end else if (latch_strobe && awaddr_q <= `OFF_WORD5 && latch_idx == 3'd3) begin
      if (latch_word[`CLKMODE_MSB:`CLKMODE_LSB] == 2'b01
          && latch_word[`FIELD_MSB:`FIELD_LSB] != 12'h000) begin
        fast_active_q <= 1'b1; // (R1)
        fast_cnt_q <= 24'(latch_word[`FIELD_MSB:`FIELD_LSB]) * 24'(modulus); // (R23)
      end else begin
        fast_active_q <= 1'b0; // (R24)
        fast_cnt_q <= '0;
      end
    end else if (fast_active_q && compare_tick) begin
      if (fast_cnt_q <= 24'h00_0001) begin
        fast_active_q <= 1'b0; // (R2)
        fast_cnt_q <= '0;
      end else begin
        fast_cnt_q <= fast_cnt_q - 24'h00_0001;
      end
    end
  end

  // pin and pump current follow the timer a cycle later, all registered
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fastlock_switch_pin_o <= 1'b0;
      fastlock_switch_pin_oe <= 1'b0;
      cp_current_q <= '0;
    end else begin
      fastlock_switch_pin_o <= 1'b0;
      fastlock_switch_pin_oe <= fast_active_q; // (R4)
      cp_current_q <= fast_active_q
        ? {word_q[2][`CP_CUR_MSB:`CP_CUR_LSB], 4'h0} // (R3)
        : {4'h0, word_q[2][`CP_CUR_MSB:`CP_CUR_LSB]};
    end
  end

  // ****************************************************************
  // phase resync timer
  // ****************************************************************
  // nested counters: base cycles inside, period count outside
  always_comb begin
    sync_now = (mode == frac_sdm_pkg::clkdiv_resync) && compare_tick
               && base_cnt_q == modulus - 12'h001
               && per_cnt_q >= clk_div - 12'h001; // (R13)
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      base_cnt_q <= '0;
      per_cnt_q <= '0;
    end else if (mode != frac_sdm_pkg::clkdiv_resync || clk_div == 12'h000) begin
      base_cnt_q <= '0; // (R24)
      per_cnt_q <= '0;
    end else if (compare_tick) begin // (R12)
      if (base_cnt_q >= modulus - 12'h001) begin
        base_cnt_q <= '0;
        per_cnt_q <= sync_now ? 12'h000 : per_cnt_q + 12'h001;
      end else begin
        base_cnt_q <= base_cnt_q + 12'h001;
      end
    end
  end

  // latch arms the resync; the second sync pulse after it fires it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      resync_arm_q <= 1'b0;
      sync_seen_q <= '0;
    end else if (latch_strobe) begin
      resync_arm_q <= 1'b1; // (R16)
      sync_seen_q <= '0;
    end else if (resync_arm_q && sync_now && clk_div != 12'h000) begin
      if (sync_seen_q == 2'd1) begin
        resync_arm_q <= 1'b0;
        sync_seen_q <= 2'd2;
      end else begin
        sync_seen_q <= sync_seen_q + 2'd1;
      end
    end
  end

  assign reseed = resync_arm_q && sync_now && clk_div != 12'h000 && sync_seen_q == 2'd1;

  // registered sync and resync strobes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_pulse_q <= 1'b0;
      phase_resync_q <= 1'b0;
      divider_offset_q <= '0;
    end else begin
      sync_pulse_q <= sync_now && clk_div != 12'h000;
      phase_resync_q <= reseed; // (R19)
      divider_offset_q <= shaper_dn;
    end
  end

  // ****************************************************************
  // noise shaper
  // ****************************************************************
  always_comb begin
    cfg.modulus = modulus;
    cfg.frac = (frac_q < modulus) ? frac_q : modulus - 12'h001;
    cfg.phase = word_q[1][27:16];
    cfg.dither = word_q[2][`DITHER_BIT];
  end

  // reseeding at the resync instant restarts from the same phase each time
  noise_shaper #(
    .W(12)
  ) u_shaper (
    .clk(clk),
    .rst_n(rst_n),
    .step(compare_tick), // (R8)
    .reseed(reseed), // (R11)
    .cfg(cfg),
    .dn_q(shaper_dn)
  );

endmodule : frac_sdm_fastlock_resync

// file: core/frac_sdm_map.svh
// register layout, field positions, reset values and codes for the synthesizer core
`ifndef FRAC_SDM_MAP_SVH
`define FRAC_SDM_MAP_SVH

// ****************************************************************
// axi4-lite byte offsets
// ****************************************************************
`define OFF_WORD0      8'h00
`define OFF_WORD1      8'h04
`define OFF_WORD2      8'h08
`define OFF_WORD3      8'h0C
`define OFF_WORD4      8'h10
`define OFF_WORD5      8'h14
`define OFF_FRAC       8'h18
`define OFF_STATUS     8'h1C
`define OFF_PHASE_OUT  8'h20

// ****************************************************************
// field positions
// ****************************************************************
`define ADDR_LSB       0
`define ADDR_MSB       2
`define FIELD_LSB      3
`define FIELD_MSB      14
`define CLKMODE_LSB    15
`define CLKMODE_MSB    16
`define DITHER_BIT     17
`define CP_CUR_LSB     9
`define CP_CUR_MSB     12

// ****************************************************************
// reset values and codes
// ****************************************************************
`define RST_WORD       32'h0000_0000
`define RST_MODULUS    12'h002
`define LFSR_SEED      21'h1F_FFFF
`define LFSR_TAP       21'h14_0000
`define CP_BOOST_SHIFT 4

`endif

// file: core/frac_sdm_pkg.sv
// shared types for the synthesizer digital core
package frac_sdm_pkg;

  // clock divider mode field of control word 3
  typedef enum logic [1:0] {
    clkdiv_off      = 2'b00,
    clkdiv_fastlock = 2'b01,
    clkdiv_resync   = 2'b10,
    clkdiv_rsvd     = 2'b11
  } clkdiv_mode_e;

  // settings handed to the noise shaper
  typedef struct packed {
    logic [11:0] modulus;
    logic [11:0] frac;
    logic [11:0] phase;
    logic dither;
  } shaper_cfg_s;

endpackage : frac_sdm_pkg

// file: core/noise_shaper.sv
// third-order mash noise shaper with optional lfsr dither
`timescale 1ns/1ps
`include "frac_sdm_map.svh"
module noise_shaper #(
  parameter int W = 12
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic step,
  input wire logic reseed,
  input frac_sdm_pkg::shaper_cfg_s cfg,
  // output
  output logic signed [3:0] dn_q
);

  logic [W-1:0] acc1_q, acc2_q, acc3_q;
  logic [W:0] s1, s2, s3;
  logic c1, c2, c3;
  logic c2_q, c3_q, c3_qq;
  logic [20:0] lfsr_q;
  logic [W-1:0] fr_in;

  // lsb dither stretches the period to the lfsr length
  always_comb begin
    fr_in = cfg.frac;
    if (cfg.dither && lfsr_q[0] && (cfg.frac < cfg.modulus - 12'h001)) begin
      fr_in = cfg.frac + 12'h001; // (R10)
    end
  end

  // modular adders against the divisor base, one per stage
  always_comb begin
    s1 = {1'b0, acc1_q} + {1'b0, fr_in};
    c1 = (s1 >= {1'b0, cfg.modulus});
    if (c1) s1 = s1 - {1'b0, cfg.modulus};
    s2 = {1'b0, acc2_q} + s1;
    c2 = (s2 >= {1'b0, cfg.modulus});
    if (c2) s2 = s2 - {1'b0, cfg.modulus};
    s3 = {1'b0, acc3_q} + s2;
    c3 = (s3 >= {1'b0, cfg.modulus});
    if (c3) s3 = s3 - {1'b0, cfg.modulus};
  end

  // accumulators: first seeded from the phase word, others cleared, so with dither off the sequence repeats (the lfsr is not reseeded)
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc1_q <= '0;
      acc2_q <= '0;
      acc3_q <= '0;
      c2_q <= 1'b0;
      c3_q <= 1'b0;
      c3_qq <= 1'b0;
      dn_q <= '0;
    end else if (reseed) begin
      acc1_q <= cfg.phase; // (R11) (R18)
      acc2_q <= '0;
      acc3_q <= '0;
      c2_q <= 1'b0;
      c3_q <= 1'b0;
      c3_qq <= 1'b0;
      dn_q <= '0;
    end else if (step) begin // (R8)
      acc1_q <= s1[W-1:0];
      acc2_q <= s2[W-1:0];
      acc3_q <= s3[W-1:0];
      c2_q <= c2;
      c3_q <= c3;
      c3_qq <= c3_q;
      // mash 1-1-1 combine: c1 + (1-z^-1)c2 + (1-z^-1)^2 c3
      dn_q <= 4'(signed'({3'b000, c1})) + 4'(signed'({3'b000, c2})) - 4'(signed'({3'b000, c2_q}))
            + 4'(signed'({3'b000, c3})) - 4'(signed'({2'b00, c3_q, 1'b0}))
            + 4'(signed'({3'b000, c3_qq})); // (R6) (R9)
    end
  end

  // dither source, maximal length 2^21-1
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lfsr_q <= `LFSR_SEED;
    end else if (step && cfg.dither) begin
      lfsr_q <= lfsr_q[0] ? ((lfsr_q >> 1) ^ `LFSR_TAP) : (lfsr_q >> 1); // (R10)
    end
  end

endmodule : noise_shaper

// file: testbench/frac_sdm_fastlock_resync_assertions.sv
// concurrent checks on the synthesizer control core ports
`timescale 1ns/1ps
module frac_sdm_fastlock_resync_assertions (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // loop control
  input wire logic fastlock_switch_pin_o,
  input wire logic fastlock_switch_pin_oe,
  input wire logic [7:0] cp_current_q,
  input wire logic sync_pulse_q,
  input wire logic phase_resync_q,
  input wire logic signed [3:0] divider_offset_q
);
  // ****************************************************************
  // properties
  // ****************************************************************
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  pin_ground_a: assert property (fastlock_switch_pin_oe |-> !fastlock_switch_pin_o)
    else $error("switch pin driven high");
  cp_boost_a: assert property (fastlock_switch_pin_oe |-> cp_current_q[3:0] == 4'h0)
    else $error("charge pump not boosted");
  cp_restore_a: assert property ($fell(fastlock_switch_pin_oe) |->
    cp_current_q == ($past(cp_current_q) >> 4)) else $error("charge pump not restored");
  pin_hold_a: assert property ($rose(fastlock_switch_pin_oe) |=> fastlock_switch_pin_oe)
    else $error("fast lock too short");
  offset_range_a: assert property (divider_offset_q >= -4'sd3 && divider_offset_q <= 4'sd4)
    else $error("shaper output out of range");
  sync_single_a: assert property (sync_pulse_q |=> !sync_pulse_q)
    else $error("sync pulses too close");
  resync_on_sync_a: assert property (phase_resync_q |-> sync_pulse_q || $past(sync_pulse_q))
    else $error("resync without sync pulse");
  bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  write_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response late");
  read_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");

  // main scenarios reached
  cover property ($rose(fastlock_switch_pin_oe));
  cover property (phase_resync_q);
  cover property (s_axi_bvalid && s_axi_bready);
endmodule : frac_sdm_fastlock_resync_assertions

// file: testbench/host_model.sv
// host side model: axi4-lite master that programs the control words
`timescale 1ns/1ps
module host_model (
  // clock
  input wire logic clk,
  // write channels
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  // read channels
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  // ****************************************************************
  // bus cycles
  // ****************************************************************
  // idle bus at time zero
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end

  // whole 32-bit word; each half dropped only once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk);
      if (!aw_ok && s_axi_awready) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    s_axi_bready <= 1'b1;
    do @(posedge clk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd

  // one power-up pass, words 5 down to 0
  task automatic power_up(input logic [31:0] w1, input logic [31:0] w2);
    logic [1:0] r;
    for (int i = 5; i >= 0; i--) begin
      wr(8'(4 * i), (i == 1) ? w1 : (i == 2) ? w2 : 32'(i), r);
    end
  endtask : power_up
endmodule : host_model

// file: testbench/test_frac_sdm_fastlock_resync.sv
// self-checking bench for the synthesizer control core
`timescale 1ns/1ps
`define chk(n, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; \
  $display("wrong value %s exp %0h got %0h", n, e, g); end end
module test_frac_sdm_fastlock_resync;
  logic clk, rst_n, tick, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic fastlock_switch_pin_o, fastlock_switch_pin_oe, sync_pulse_q, phase_resync_q;
  logic [7:0] s_axi_awaddr, s_axi_araddr, cp_current_q;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic signed [3:0] divider_offset_q;
  logic [3:0] cp;
  logic [11:0] ph;
  int n_errors, checks, cycles, seed, sum, cnt, oe_cnt, rs_at;
  logic signed [3:0] s [18];
  int q[$];

  // ****************************************************************
  // clock, parts and monitor
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  frac_sdm_fastlock_resync i_frac_sdm_fastlock_resync (.clk, .rst_n, .compare_tick(tick),
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF),
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .fastlock_switch_pin_o, .fastlock_switch_pin_oe, .cp_current_q, .sync_pulse_q,
    .phase_resync_q, .divider_offset_q);
  host_model i_host_model (.clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  // background watch, so no pulse is missed while a bus task runs
  always @(posedge clk) begin
    cycles++;
    if (fastlock_switch_pin_oe === 1'b1) begin
      oe_cnt++;
      `chk("cp boost", {cp, 4'h0}, cp_current_q)
    end
    if (sync_pulse_q === 1'b1) q.push_back(cycles);
    if (phase_resync_q === 1'b1) rs_at = cycles;
    if (cycles == 4000) begin
      n_errors++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_sim

  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    {n_errors, checks, cycles, oe_cnt, rs_at} = '0;
    seed = 57;
    rst_n = 1'b0;
    tick = 1'b1;
    cp = 4'($random(seed));
    ph = 12'($random(seed));
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    // base 3, dither off, random phase word kept constant afterwards
    i_host_model.power_up({4'h0, ph, 1'b0, 12'd3, 3'd1}, {19'h0, cp, 6'h0, 3'd2});
    i_host_model.rd(8'h08, d, r);
    `chk("word 2", {19'h0, cp, 6'h0, 3'd2}, d)
    i_host_model.rd(8'h30, d, r);
    `chk("unmapped resp", 2'b10, r)
    repeat (20) @(posedge clk);
    `chk("idle fast lock", 0, oe_cnt)
    `chk("idle syncs", 0, q.size())
    `chk("cp normal", {4'h0, cp}, cp_current_q)
    $display("test power-up done");
    // one step per compare tick, period 3 x base for a base of 3
    i_host_model.wr(8'h18, 32'h0000_0001, r);
    `chk("frac resp", 2'b00, r)
    // the first samples still carry the all-zero history, not the loop's
    repeat (9) @(posedge clk);
    for (int i = 0; i < 18; i++) begin
      @(posedge clk);
      s[i] = divider_offset_q;
    end
    sum = 0;
    for (int i = 0; i < 9; i++) begin
      sum += s[i];
      `chk("repeat", s[i], s[i + 9])
    end
    `chk("mean step", 3, sum)
    $display("test shaper done");
    oe_cnt = 0;
    i_host_model.wr(8'h0C, {15'h0, 2'b01, 12'd4, 3'd3}, r);
    repeat (40) @(posedge clk);
    `chk("fast lock length", 4 * 3, oe_cnt)
    `chk("cp after", {4'h0, cp}, cp_current_q)
    `chk("pin level", 1'b0, fastlock_switch_pin_o)
    $display("test fast lock done");
    q.delete();
    i_host_model.wr(8'h0C, {15'h0, 2'b10, 12'd2, 3'd3}, r);
    repeat (40) @(posedge clk);
    `chk("sync gap", 2 * 3, q[1] - q[0])
    cnt = 0;
    foreach (q[i]) if (q[i] <= rs_at) cnt++;
    `chk("syncs to resync", 2, cnt)
    $display("test resync done");
    i_host_model.wr(8'h0C, 32'h0000_0003, r);
    repeat (4) @(posedge clk);
    q.delete();
    repeat (30) @(posedge clk);
    `chk("syncs off", 0, q.size())
    $display("test mode off done");
    end_sim();
  end
endmodule : test_frac_sdm_fastlock_resync

bind frac_sdm_fastlock_resync frac_sdm_fastlock_resync_assertions i_chk (.clk, .rst_n,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .fastlock_switch_pin_o, .fastlock_switch_pin_oe, .cp_current_q, .sync_pulse_q,
  .phase_resync_q, .divider_offset_q);
